// file: src/cise_pkg.sv
// shared constants and types of the instruction subset executor
package cise_pkg;
  // instruction classes of this subset
  typedef enum logic [3:0] {
    op_other,
    branch_on_zero_op,
    branch_on_overflow_op,
    bit_invert_op,
    call_op,
    zero_fill_op,
    watchdog_kick_op,
    invert_file_op,
    compare_equal_skip_op
  } cise_op_t;
  // sequencer modes of one instruction cycle
  typedef enum logic [1:0] {m_exec, m_nop, m_skip, m_call2} cise_mode_t;
  // opcode patterns
  localparam logic [7:0] BR_ZERO_HI = 8'he0;
  localparam logic [7:0] BR_OVF_HI = 8'he4;
  localparam logic [3:0] BIT_INV_HI = 4'h7;
  localparam logic [6:0] CALL_HI = 7'h76;
  localparam logic [3:0] WORD2_HI = 4'hf;
  localparam logic [6:0] ZERO_FILL_HI = 7'h35;
  localparam logic [6:0] CMP_EQ_HI = 7'h31;
  localparam logic [5:0] INV_FILE_HI = 6'h07;
  localparam logic [15:0] KICK_OP = 16'h0004;
  localparam logic [7:0] GOTO_HI = 8'hef;
  localparam logic [7:0] LFSR_HI = 8'hee;
  localparam logic [3:0] MOVFF_HI = 4'hc;
  // quarter phases of an instruction cycle
  localparam logic [1:0] PH_FETCH = 2'h0;
  localparam logic [1:0] PH_READ = 2'h1;
  localparam logic [1:0] PH_PROC = 2'h2;
  localparam logic [1:0] PH_WRITE = 2'h3;
  // status bit positions
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_OV = 3;
  localparam int ST_N = 4;
  // access bank split
  localparam logic [7:0] ACC_SPLIT = 8'h60;
  localparam logic [3:0] ACC_HI_PAGE = 4'hf;
  // program counter steps
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [20:0] PC_RET = 21'h000004;
  // register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ACC = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_BANK = 8'h0c;
  localparam logic [7:0] REG_IDX = 8'h10;
  localparam logic [7:0] REG_SHADOW = 8'h14;
  localparam logic [7:0] REG_PC = 8'h18;
  localparam logic [7:0] REG_PWR = 8'h1c;
  // field positions and reset values
  localparam int CTRL_RUN = 0;
  localparam int CTRL_EXT = 1;
  localparam int PWR_EXPIRY = 0;
  localparam int PWR_POWERDOWN = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [4:0] STATUS_RST = 5'h00;
  localparam logic [20:0] PC_RST = 21'h000000;
endpackage

// file: src/cise_dec_if.sv
// decoder interface between core and instruction decoder
interface cise_dec_if;
  logic [15:0] ir;
  cise_pkg::cise_op_t op;
  logic [7:0] f;
  logic [2:0] b;
  logic a;
  logic d;
  logic s;
  logic two_word;
  modport dec(input ir, output op, f, b, a, d, s, two_word);
  modport core(output ir, input op, f, b, a, d, s, two_word);
endinterface

// file: src/cise_decode.sv
// combinational decoder of the instruction subset
module cise_decode (
  cise_dec_if.dec dif
);
  // opcode class
  always_comb
  begin
    dif.op = cise_pkg::op_other;
    if (dif.ir == cise_pkg::KICK_OP)
      dif.op = cise_pkg::watchdog_kick_op;
    else if (dif.ir[15:8] == cise_pkg::BR_ZERO_HI)
      dif.op = cise_pkg::branch_on_zero_op;
    else if (dif.ir[15:8] == cise_pkg::BR_OVF_HI)
      dif.op = cise_pkg::branch_on_overflow_op;
    else if (dif.ir[15:12] == cise_pkg::BIT_INV_HI)
      dif.op = cise_pkg::bit_invert_op;
    else if (dif.ir[15:9] == cise_pkg::CALL_HI)
      dif.op = cise_pkg::call_op;
    else if (dif.ir[15:9] == cise_pkg::ZERO_FILL_HI)
      dif.op = cise_pkg::zero_fill_op;
    else if (dif.ir[15:10] == cise_pkg::INV_FILE_HI)
      dif.op = cise_pkg::invert_file_op;
    else if (dif.ir[15:9] == cise_pkg::CMP_EQ_HI)
      dif.op = cise_pkg::compare_equal_skip_op;
  end

  // operand fields
  assign dif.f = dif.ir[7:0];
  assign dif.b = dif.ir[11:9];
  assign dif.a = dif.ir[8];
  assign dif.d = dif.ir[9];
  assign dif.s = dif.ir[8];
  // first words of two-word instructions
  assign dif.two_word = (dif.ir[15:9] == cise_pkg::CALL_HI) || (dif.ir[15:8] == cise_pkg::GOTO_HI)
    || (dif.ir[15:8] == cise_pkg::LFSR_HI) || (dif.ir[15:12] == cise_pkg::MOVFF_HI);
endmodule

// file: src/cise_core.sv
// instruction subset executor with wishbone register slave
//
// Contract
// - branch_on_zero_op with zero set loads pc+2+2n and takes two cycles, else one.
// - branch_on_overflow_op with overflow set loads pc+2+2n.
// - a branch not taken spends one cycle and leaves pc at the next instruction.
// - bit_invert_op inverts bit b of the file register by read-modify-write in one cycle.
// - a call pushes pc+4 onto the return stack.
// - a call loads k into pc bits 20:1 and with s set saves accumulator, flags and bank pointer to shadows.
// - zero_fill_op writes zero to the file register and sets the zero flag.
// - with a clear the access bank is used, or idx_base+f for f below ACC_SPLIT when CTRL_EXT is set; with a set the bank pointer selects the bank.
// - watchdog_kick_op clears the watchdog and postscaler and sets expiry and powerdown flags.
module cise_core #(
  parameter int DMEM_AW = 12
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [20:0] prog_addr,
  input wire logic [15:0] prog_data,
  output logic [DMEM_AW-1:0] dmem_addr,
  input wire logic [7:0] dmem_rdata,
  output logic [7:0] dmem_wdata,
  output logic dmem_we,
  output logic stack_push,
  output logic [20:0] stack_data,
  output logic watchdog_kick
);
  if (DMEM_AW != 12)
  begin : g_chk
    $error("data address width must be 12");
  end

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [1:0] phase;
  cise_pkg::cise_mode_t mode;
  cise_pkg::cise_mode_t pend_mode;
  logic [15:0] ir;
  logic [20:0] pc;
  logic [7:0] klo;
  logic [7:0] w;
  logic [4:0] status;
  logic [3:0] bank_pointer;
  logic [11:0] idx_base;
  logic [1:0] ctrl;
  logic [7:0] accumulator_shadow;
  logic [4:0] flags_shadow;
  logic [3:0] bank_pointer_shadow;
  logic expiry_flag;
  logic powerdown_flag;
  logic [31:0] rd_mux;
  cise_dec_if dif();

  cise_decode u_dec (
    .dif(dif)
  );

  // effective file address
  function automatic logic [11:0] eff_addr(input logic [7:0] f, input logic a, input logic ext,
                                           input logic [3:0] bp, input logic [11:0] base);
    if (a)
      return {bp, f};
    else if (ext && f < cise_pkg::ACC_SPLIT)
      return base + {4'h0, f};
    else if (f < cise_pkg::ACC_SPLIT)
      return {4'h0, f};
    else
      return {cise_pkg::ACC_HI_PAGE, f};
  endfunction

  // byte-lane merge of a register write
  function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        r[i*8 +: 8] = dat[i*8 +: 8];
    end
    return r;
  endfunction

  assign dif.ir = ir;
  assign prog_addr = pc;
  wire advance = ctrl[cise_pkg::CTRL_RUN] || phase != cise_pkg::PH_FETCH || mode != cise_pkg::m_exec;
  wire exec_proc = mode == cise_pkg::m_exec && phase == cise_pkg::PH_PROC;
  wire [20:0] br_target = pc + cise_pkg::PC_STEP + {{12{ir[7]}}, ir[7:0], 1'b0};
  wire [20:0] call_dest = {ir[11:0], klo, 1'b0};
  wire [7:0] inv_rd = ~dmem_rdata;
  wire [7:0] bit_mask = 8'h01 << dif.b;
  wire wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o; // write lands at the ack edge

  ////////////////////////////////////////////////////////////////////////
  // quarter-phase sequencer
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      phase <= cise_pkg::PH_FETCH;
      mode <= cise_pkg::m_exec;
    end
    else if (advance)
    begin
      phase <= phase + 2'h1;
      if (phase == cise_pkg::PH_WRITE)
        mode <= pend_mode;
    end
  end

  // fetch, program counter and mode choice
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      ir <= 16'h0000;
      pc <= cise_pkg::PC_RST;
      klo <= 8'h00;
      pend_mode <= cise_pkg::m_exec;
    end
    else if (phase == cise_pkg::PH_FETCH)
      ir <= prog_data;
    else if (phase == cise_pkg::PH_PROC)
    begin
      pend_mode <= cise_pkg::m_exec;
      pc <= pc + cise_pkg::PC_STEP;
      case (mode)
        cise_pkg::m_exec:
        begin
          case (dif.op)
            cise_pkg::branch_on_zero_op:
            begin
              if (status[cise_pkg::ST_Z])
              begin
                pc <= br_target;
                pend_mode <= cise_pkg::m_nop;
              end
            end
            cise_pkg::branch_on_overflow_op:
            begin
              if (status[cise_pkg::ST_OV])
              begin
                pc <= br_target;
                pend_mode <= cise_pkg::m_nop;
              end
            end
            cise_pkg::call_op:
            begin
              klo <= dif.f;
              pend_mode <= cise_pkg::m_call2;
            end
            cise_pkg::compare_equal_skip_op:
            begin
              if (dmem_rdata == w)
                pend_mode <= cise_pkg::m_skip;
            end
            default:
            begin
            end
          endcase
        end
        cise_pkg::m_call2:
          pc <= call_dest;
        cise_pkg::m_skip:
        begin
          if (dif.two_word)
          begin
            pc <= pc + cise_pkg::PC_RET;
            pend_mode <= cise_pkg::m_nop;
          end
        end
        default:
          pc <= pc;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data memory address and write-back
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      dmem_addr <= 12'h000;
      dmem_wdata <= 8'h00;
      dmem_we <= 1'b0;
    end
    else
    begin
      dmem_we <= 1'b0;
      if (mode == cise_pkg::m_exec && phase == cise_pkg::PH_READ)
        dmem_addr <= eff_addr(dif.f, dif.a, ctrl[cise_pkg::CTRL_EXT], bank_pointer, idx_base);
      if (exec_proc && dif.op == cise_pkg::bit_invert_op)
      begin
        dmem_wdata <= dmem_rdata ^ bit_mask;
        dmem_we <= 1'b1;
      end
      if (exec_proc && dif.op == cise_pkg::zero_fill_op)
      begin
        dmem_wdata <= 8'h00;
        dmem_we <= 1'b1;
      end
      if (exec_proc && dif.op == cise_pkg::invert_file_op && dif.d)
      begin
        dmem_wdata <= inv_rd;
        dmem_we <= 1'b1;
      end
    end
  end

  // accumulator, flags and bank pointer; hardware updates follow software writes
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      ctrl <= cise_pkg::CTRL_RST;
      w <= 8'h00;
      status <= cise_pkg::STATUS_RST;
      bank_pointer <= 4'h0;
      idx_base <= 12'h000;
    end
    else
    begin
      if (wb_wr && wb_adr_i == cise_pkg::REG_CTRL)
        ctrl <= 2'(wb_merge({30'h0, ctrl}, wb_dat_i, wb_sel_i));
      if (wb_wr && wb_adr_i == cise_pkg::REG_ACC)
        w <= 8'(wb_merge({24'h0, w}, wb_dat_i, wb_sel_i));
      if (wb_wr && wb_adr_i == cise_pkg::REG_STATUS)
        status <= 5'(wb_merge({27'h0, status}, wb_dat_i, wb_sel_i));
      if (wb_wr && wb_adr_i == cise_pkg::REG_BANK)
        bank_pointer <= 4'(wb_merge({28'h0, bank_pointer}, wb_dat_i, wb_sel_i));
      if (wb_wr && wb_adr_i == cise_pkg::REG_IDX)
        idx_base <= 12'(wb_merge({20'h0, idx_base}, wb_dat_i, wb_sel_i));
      if (exec_proc && dif.op == cise_pkg::zero_fill_op)
        status[cise_pkg::ST_Z] <= 1'b1;
      if (exec_proc && dif.op == cise_pkg::invert_file_op)
      begin
        if (!dif.d)
          w <= inv_rd;
        status[cise_pkg::ST_N] <= inv_rd[7];
        status[cise_pkg::ST_Z] <= inv_rd == 8'h00;
      end
    end
  end

  // shadow save and return stack push of a call
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      accumulator_shadow <= 8'h00;
      flags_shadow <= 5'h00;
      bank_pointer_shadow <= 4'h0;
      stack_push <= 1'b0;
      stack_data <= 21'h000000;
    end
    else
    begin
      stack_push <= exec_proc && dif.op == cise_pkg::call_op;
      if (exec_proc && dif.op == cise_pkg::call_op)
      begin
        stack_data <= pc + cise_pkg::PC_RET;
        if (dif.s)
        begin
          accumulator_shadow <= w;
          flags_shadow <= status;
          bank_pointer_shadow <= bank_pointer;
        end
      end
    end
  end

  // watchdog kick and power flags; a kick wins over a software clear
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      watchdog_kick <= 1'b0;
      expiry_flag <= 1'b1;
      powerdown_flag <= 1'b1;
    end
    else
    begin
      watchdog_kick <= exec_proc && dif.op == cise_pkg::watchdog_kick_op;
      if (wb_wr && wb_adr_i == cise_pkg::REG_PWR && wb_sel_i[0])
      begin
        expiry_flag <= expiry_flag & wb_dat_i[cise_pkg::PWR_EXPIRY];
        powerdown_flag <= powerdown_flag & wb_dat_i[cise_pkg::PWR_POWERDOWN];
      end
      if (exec_proc && dif.op == cise_pkg::watchdog_kick_op)
      begin
        expiry_flag <= 1'b1;
        powerdown_flag <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wishbone read decode
  always_comb
  begin
    rd_mux = 32'h00000000;
    if (wb_adr_i == cise_pkg::REG_CTRL)
      rd_mux = {30'h0, ctrl};
    else if (wb_adr_i == cise_pkg::REG_ACC)
      rd_mux = {24'h0, w};
    else if (wb_adr_i == cise_pkg::REG_STATUS)
      rd_mux = {27'h0, status};
    else if (wb_adr_i == cise_pkg::REG_BANK)
      rd_mux = {28'h0, bank_pointer};
    else if (wb_adr_i == cise_pkg::REG_IDX)
      rd_mux = {20'h0, idx_base};
    else if (wb_adr_i == cise_pkg::REG_SHADOW)
      rd_mux = {12'h0, bank_pointer_shadow, 3'h0, flags_shadow, accumulator_shadow};
    else if (wb_adr_i == cise_pkg::REG_PC)
      rd_mux = {11'h0, pc};
    else if (wb_adr_i == cise_pkg::REG_PWR)
      rd_mux = {30'h0, powerdown_flag, expiry_flag};
  end

  // wishbone answer one cycle after the strobe
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o)
        wb_dat_o <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence s_nop_cycle;
    ##1 (mode == cise_pkg::m_nop);
  endsequence

  property p_bz_taken;
    exec_proc && dif.op == cise_pkg::branch_on_zero_op && status[cise_pkg::ST_Z]
      |=> pc == $past(br_target) ##0 s_nop_cycle;
  endproperty
  a_bz_taken: assert property (p_bz_taken) else $error("zero branch not taken");

  property p_bov_taken;
    exec_proc && dif.op == cise_pkg::branch_on_overflow_op && status[cise_pkg::ST_OV]
      |=> pc == $past(br_target) ##0 s_nop_cycle;
  endproperty
  a_bov_taken: assert property (p_bov_taken) else $error("overflow branch not taken");

  property p_not_taken;
    exec_proc && ((dif.op == cise_pkg::branch_on_zero_op && !status[cise_pkg::ST_Z])
      || (dif.op == cise_pkg::branch_on_overflow_op && !status[cise_pkg::ST_OV]))
      |=> pc == $past(pc) + cise_pkg::PC_STEP ##1 mode == cise_pkg::m_exec;
  endproperty
  a_not_taken: assert property (p_not_taken) else $error("untaken branch wrong");

  property p_bit_invert;
    exec_proc && dif.op == cise_pkg::bit_invert_op |=> dmem_we && dmem_wdata == ($past(dmem_rdata) ^ $past(bit_mask));
  endproperty
  a_bit_invert: assert property (p_bit_invert) else $error("bit invert wrong");

  property p_call_push;
    exec_proc && dif.op == cise_pkg::call_op |=> stack_push && stack_data == $past(pc) + cise_pkg::PC_RET;
  endproperty
  a_call_push: assert property (p_call_push) else $error("return address wrong");

  property p_call_load;
    mode == cise_pkg::m_call2 && phase == cise_pkg::PH_PROC |=> pc == $past(call_dest);
  endproperty
  a_call_load: assert property (p_call_load) else $error("call target wrong");

  property p_zero_fill;
    exec_proc && dif.op == cise_pkg::zero_fill_op |=> dmem_we && dmem_wdata == 8'h00 && status[cise_pkg::ST_Z];
  endproperty
  a_zero_fill: assert property (p_zero_fill) else $error("zero fill wrong");

  property p_kick;
    exec_proc && dif.op == cise_pkg::watchdog_kick_op |=> watchdog_kick && expiry_flag && powerdown_flag ##1 !watchdog_kick;
  endproperty
  a_kick: assert property (p_kick) else $error("watchdog kick wrong");

  property p_skip;
    exec_proc && dif.op == cise_pkg::compare_equal_skip_op && dmem_rdata == w |-> ##2 mode == cise_pkg::m_skip;
  endproperty
  a_skip: assert property (p_skip) else $error("equal skip missing");
endmodule

// file: testbench/testbench.sv
// self-checking bench of the instruction subset executor
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // one test program with its set-up and expected outcome
  typedef struct packed {
    logic [95:0] p;
    logic [15:0] pre;
    logic [3:0] bank;
    logic ext;
    logic [19:0] c0;
    logic [19:0] c1;
    logic [15:0] res;
    logic [3:0] ev;
    logic [7:0] gap;
  } cise_row_t;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hf;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [20:0] prog_addr;
  logic [15:0] prog_data;
  logic [11:0] dmem_addr;
  logic [7:0] dmem_rdata;
  logic [7:0] dmem_wdata;
  logic dmem_we;
  logic stack_push;
  logic [20:0] stack_data;
  logic watchdog_kick;
  logic [15:0] pmem [64];
  logic [7:0] dmem [4096];
  cise_row_t rows [24];
  int miscompares = 0;
  int samples_checked = 0;
  int npush = 0;
  int nkick = 0;
  int nwe = 0;
  time tw0 = 0;
  time tw1 = 0;

  always #4 clk_sys = ~clk_sys;

  cise_core #(.DMEM_AW(12)) i_cise_core (
    .clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .prog_addr(prog_addr), .prog_data(prog_data), .dmem_addr(dmem_addr), .dmem_rdata(dmem_rdata),
    .dmem_wdata(dmem_wdata), .dmem_we(dmem_we), .stack_push(stack_push), .stack_data(stack_data),
    .watchdog_kick(watchdog_kick)
  );

  // program and file memories answer in the same cycle
  assign prog_data = pmem[prog_addr[6:1]];
  assign dmem_rdata = dmem[dmem_addr];

  // file writes, pulse counts and times of the first two writes
  always @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      npush <= 0;
      nkick <= 0;
      nwe <= 0;
    end
    else
    begin
      npush <= npush + int'(stack_push);
      nkick <= nkick + int'(watchdog_kick);
      if (dmem_we === 1'b1)
      begin
        if (nwe == 0) tw0 <= $time;
        if (nwe == 1) tw1 <= $time;
        nwe <= nwe + 1;
        dmem[dmem_addr] <= dmem_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic bus cycle, held until ack is seen at an edge
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= dat;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 16);
    q = wb_dat_o;
    if (n >= 16) chk(32'h0, 32'h1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk_sys);
  endtask

  // load a program, run it into its halt loop, stop and look
  task automatic run_row(input cise_row_t r);
    logic [31:0] q;
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 64; i++)
      pmem[i] = (i < 6) ? r.p[95 - 16 * i -: 16] : (i[0] ? 16'he0fe : 16'he4ff);
    for (int i = 0; i < 4096; i++)
      dmem[i] = 8'h5a;
    reset_n <= 1'b1;
    @(posedge clk_sys);
    wb(1'b1, cise_pkg::REG_ACC, 32'(r.pre[7:0]), q);
    wb(1'b1, cise_pkg::REG_STATUS, 32'(r.pre[15:8]), q);
    wb(1'b1, cise_pkg::REG_BANK, 32'(r.bank), q);
    wb(1'b1, cise_pkg::REG_IDX, 32'h500, q);
    wb(1'b1, cise_pkg::REG_PWR, 32'h0, q);
    wb(1'b1, cise_pkg::REG_CTRL, {30'h0, r.ext, 1'b1}, q);
    repeat (80) @(posedge clk_sys);
    wb(1'b1, cise_pkg::REG_CTRL, 32'h0, q);
    repeat (16) @(posedge clk_sys);
    chk(32'(dmem[r.c0[19:8]]), 32'(r.c0[7:0]));
    chk(32'(dmem[r.c1[19:8]]), 32'(r.c1[7:0]));
    wb(1'b0, cise_pkg::REG_ACC, 32'h0, q);
    chk(q, 32'(r.res[7:0]));
    wb(1'b0, cise_pkg::REG_STATUS, 32'h0, q);
    chk(q, 32'(r.res[15:8]));
    wb(1'b0, cise_pkg::REG_PWR, 32'h0, q);
    chk(q, (r.ev[1:0] != 2'h0) ? 32'h3 : 32'h0);
    chk(32'(nkick), 32'(r.ev[1:0]));
    chk(32'(npush), 32'(r.ev[3:2]));
    if (r.gap != 8'h00) chk(32'((tw1 - tw0) / 8), 32'(r.gap));
    if (r.ev[3:2] != 2'h0)
    begin
      chk(32'(stack_data), 32'h4);
      wb(1'b0, cise_pkg::REG_PC, 32'h0, q);
      chk(32'(q[20:7]), 32'h4);
      wb(1'b0, cise_pkg::REG_SHADOW, 32'h0, q);
      if (r.p[88]) chk(q, {12'h0, r.bank, 3'h0, r.pre[12:8], r.pre[7:0]});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    complete_run();
  end

  // table of programs, then reset and register corner cases
  initial
  begin
    logic [31:0] q;
    for (int i = 0; i < 64; i++)
      pmem[i] = 16'he4ff;
    rows = '{
      '{96'he004_6a40_e4ff_e0fe_e4ff_6a41, 16'h0400, 4'h0, 1'b0, 20'h0405a, 20'h04100, 16'h0400, 4'h0, 8'h00},
      '{96'he004_6a40_e4ff_e0fe_e4ff_6a41, 16'h0800, 4'h0, 1'b0, 20'h04000, 20'h0415a, 16'h0c00, 4'h0, 8'h00},
      '{96'he404_6a40_e4ff_e0fe_e4ff_6a41, 16'h0800, 4'h0, 1'b0, 20'h0405a, 20'h04100, 16'h0c00, 4'h0, 8'h00},
      '{96'he404_6a40_e4ff_e0fe_e4ff_6a41, 16'h0400, 4'h0, 1'b0, 20'h04000, 20'h0415a, 16'h0400, 4'h0, 8'h00},
      '{96'hec05_f001_e4ff_e0fe_e4ff_6a41, 16'h0833, 4'h2, 1'b0, 20'h0405a, 20'h04100, 16'h0c33, 4'h4, 8'h00},
      '{96'hed05_f001_e4ff_e0fe_e4ff_6a41, 16'h0b33, 4'h2, 1'b0, 20'h0405a, 20'h04100, 16'h0f33, 4'h4, 8'h00},
      '{96'h7720_e4ff_e0fe_e4ff_e0fe_e4ff, 16'h0800, 4'h2, 1'b0, 20'h22052, 20'h0205a, 16'h0800, 4'h0, 8'h00},
      '{96'h6b10_e4ff_e0fe_e4ff_e0fe_e4ff, 16'h0800, 4'h3, 1'b0, 20'h31000, 20'h0105a, 16'h0c00, 4'h0, 8'h00},
      '{96'h6a20_e4ff_e0fe_e4ff_e0fe_e4ff, 16'h0800, 4'h0, 1'b1, 20'h52000, 20'h0205a, 16'h0c00, 4'h0, 8'h00},
      '{96'h6a20_e4ff_e0fe_e4ff_e0fe_e4ff, 16'h0800, 4'h0, 1'b0, 20'h02000, 20'h5205a, 16'h0c00, 4'h0, 8'h00},
      '{96'h6a5f_e4ff_e0fe_e4ff_e0fe_e4ff, 16'h0800, 4'h0, 1'b1, 20'h55f00, 20'h05f5a, 16'h0c00, 4'h0, 8'h00},
      '{96'h6a60_e4ff_e0fe_e4ff_e0fe_e4ff, 16'h0800, 4'h0, 1'b1, 20'hf6000, 20'h5605a, 16'h0c00, 4'h0, 8'h00},
      '{96'h1c30_e4ff_e0fe_e4ff_e0fe_e4ff, 16'h0800, 4'h0, 1'b0, 20'h0305a, 20'h0405a, 16'h18a5, 4'h0, 8'h00},
      '{96'h1e30_e4ff_e0fe_e4ff_e0fe_e4ff, 16'h0c00, 4'h0, 1'b0, 20'h030a5, 20'h0405a, 16'h1800, 4'h0, 8'h00},
      '{96'h6230_6a40_e4ff_e0fe_e4ff_e0fe, 16'h085a, 4'h0, 1'b0, 20'h0405a, 20'h0305a, 16'h085a, 4'h0, 8'h00},
      '{96'h6230_6a40_e4ff_e0fe_e4ff_e0fe, 16'h0811, 4'h0, 1'b0, 20'h04000, 20'h0305a, 16'h0c11, 4'h0, 8'h00},
      '{96'h6230_ef00_6a41_6a40_e4ff_e0fe, 16'h085a, 4'h0, 1'b0, 20'h0415a, 20'h04000, 16'h0c5a, 4'h0, 8'h00},
      '{96'h0004_e4ff_e0fe_e4ff_e0fe_e4ff, 16'h0800, 4'h0, 1'b0, 20'h0405a, 20'h0415a, 16'h0800, 4'h1, 8'h00},
      '{96'h6a40_e000_6a41_e4ff_e0fe_e4ff, 16'h0000, 4'h0, 1'b0, 20'h04000, 20'h04100, 16'h0400, 4'h0, 8'h0c},
      '{96'h6a40_e400_6a41_e4ff_e0fe_e4ff, 16'h0000, 4'h0, 1'b0, 20'h04000, 20'h04100, 16'h0400, 4'h0, 8'h08},
      '{96'h6a40_6230_6a41_6a42_e4ff_e0fe, 16'h005a, 4'h0, 1'b0, 20'h0415a, 20'h04200, 16'h045a, 4'h0, 8'h0c},
      '{96'h6a40_6230_ef00_6a41_6a42_e4ff, 16'h005a, 4'h0, 1'b0, 20'h0415a, 20'h04200, 16'h045a, 4'h0, 8'h10},
      '{96'h6230_c000_6a41_6a40_e4ff_e0fe, 16'h085a, 4'h0, 1'b0, 20'h0415a, 20'h04000, 16'h0c5a, 4'h0, 8'h00},
      '{96'h6230_ee00_6a41_6a40_e4ff_e0fe, 16'h085a, 4'h0, 1'b0, 20'h0415a, 20'h04000, 16'h0c5a, 4'h0, 8'h00}
    };
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    foreach (rows[i])
      run_row(rows[i]);
    // reset values, quiet outputs, unmapped and read-only places
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(32'({dmem_we, stack_push, watchdog_kick, wb_ack_o}), 32'h0);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    wb(1'b0, cise_pkg::REG_PWR, 32'h0, q);
    chk(q, 32'h3);
    wb(1'b0, cise_pkg::REG_CTRL, 32'h0, q);
    chk(q, 32'h0);
    wb(1'b0, cise_pkg::REG_STATUS, 32'h0, q);
    chk(q, 32'h0);
    wb(1'b1, 8'h20, 32'hffff_ffff, q);
    wb(1'b0, 8'h20, 32'h0, q);
    chk(q, 32'h0);
    wb(1'b1, cise_pkg::REG_PC, 32'h0001_2344, q);
    wb(1'b0, cise_pkg::REG_PC, 32'h0, q);
    chk(q, 32'h0);
    complete_run();
  end
endmodule
